// [logic/serial_port_regs.svh]
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// Byte addresses on the register bus
`define OFS_SERIAL_CONTROL 8'h98
`define OFS_SERIAL_BUFFER 8'h9c
`define OFS_TIMER_CONTROL 8'hc8
`define OFS_COUNT_LOW 8'hcc
`define OFS_COUNT_HIGH 8'hd0
`define OFS_RELOAD_LOW 8'hd4
`define OFS_RELOAD_HIGH 8'hd8
`define OFS_RATE_CONTROL 8'hdc

// Field positions
`define RATE_DOUBLE_BIT 0

// Reset values
`define RST_SERIAL_CONTROL 8'h00
`define RST_TIMER_CONTROL 8'h00
`define RST_RATE_CONTROL 8'h00

// Timing counts: machine cycle in pclk cycles, bit sampling in rate ticks
`define MC_LAST 4'hb
`define MC_MID 4'h5
`define SAMPLE_LAST 4'hf
`define SAMPLE_VOTE0 4'h7
`define SAMPLE_VOTE1 4'h8
`define SAMPLE_VOTE2 4'h9

`endif

// [logic/serial_port_pkg.sv]
package serial_port_pkg;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_8BIT = 2'h1,
    MODE_9BIT_FIXED = 2'h2,
    MODE_9BIT_VAR = 2'h3
  } uart_mode_t;

  typedef struct packed {
    uart_mode_t mode;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } serial_control_t;

  typedef struct packed {
    logic timer_overflow_flag;
    logic ext_event_flag;
    logic rx_clock_select;
    logic tx_clock_select;
    logic ext_trigger_enable;
    logic run;
    logic counter_select;
    logic capture_reload_select;
  } timer_control_t;

  typedef struct packed {
    logic wr_count_low;
    logic wr_count_high;
    logic wr_reload_low;
    logic wr_reload_high;
    logic [7:0] data;
  } timer_write_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b01,
    LINK_BUSY = 2'b10
  } link_state_t;

endpackage : serial_port_pkg

// [logic/reload_timer.sv]
`timescale 1ns/100ps
module reload_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timing and pins, already synchronised
  input wire logic mc_tick,
  input wire logic trig_level,
  input wire logic pin_level,
  // Software side
  input serial_port_pkg::timer_control_t ctrl,
  input serial_port_pkg::timer_write_t twr,
  output logic [15:0] count_q,
  output logic [15:0] reload_q,
  // Events
  output logic overflow,
  output logic tf_set,
  output logic exf_set
);

  logic trig_samp_q;
  logic pin_samp_q;
  logic trig_fall;
  logic pin_fall;
  logic baud;
  logic inc;
  logic capture_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_samp_q <= 1'b1;
      pin_samp_q <= 1'b1;
    end else if (mc_tick) begin
      trig_samp_q <= trig_level;
      pin_samp_q <= pin_level;
    end
  end

  assign trig_fall = mc_tick & trig_samp_q & ~trig_level;
  assign pin_fall = mc_tick & pin_samp_q & ~pin_level;
  assign baud = ctrl.rx_clock_select | ctrl.tx_clock_select;
  assign capture_mode = ctrl.capture_reload_select & ~baud;
  assign inc = ctrl.run & (ctrl.counter_select ? pin_fall : mc_tick);
  assign overflow = inc & (count_q == 16'hffff);
  assign tf_set = overflow & ~baud;
  assign exf_set = ctrl.ext_trigger_enable & trig_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 16'h0000;
    end else if (twr.wr_count_low || twr.wr_count_high) begin
      if (twr.wr_count_low) count_q[7:0] <= twr.data;
      if (twr.wr_count_high) count_q[15:8] <= twr.data;
    end else if (overflow && !capture_mode) begin
      count_q <= reload_q;
    end else if (exf_set && !ctrl.capture_reload_select && !baud) begin
      count_q <= reload_q;
    end else if (inc) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= 16'h0000;
    end else if (exf_set && capture_mode) begin
      reload_q <= count_q;
    end else begin
      if (twr.wr_reload_low) reload_q[7:0] <= twr.data;
      if (twr.wr_reload_high) reload_q[15:8] <= twr.data;
    end
  end

endmodule : reload_timer

// [logic/serial_port_with_reload_timer.sv]
`timescale 1ns/100ps
`include "serial_port_regs.svh"
module serial_port_with_reload_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  output logic txd,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  // Timer pins and first timer rate source
  input wire logic ext_trigger_pin,
  input wire logic count_pin,
  input wire logic t1_overflow,
  // Interrupt requests
  output logic timer_irq,
  output logic serial_irq
);

  serial_port_pkg::serial_control_t serial_control_q;
  serial_port_pkg::timer_control_t tcon_q;
  serial_port_pkg::timer_write_t twr;
  serial_port_pkg::link_state_t tx_state_q;
  serial_port_pkg::link_state_t rx_state_q;
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [3:0] mc_cnt_q;
  logic [1:0] m2_cnt_q;
  logic rate_double_q;
  logic mc_tick;
  logic mc_mid;
  logic m2_tick;
  logic [15:0] count;
  logic [15:0] reload;
  logic t2_ovf;
  logic tf_set;
  logic exf_set;
  logic wr_en;
  logic [31:0] prdata_q;
  logic [7:0] wdata;
  logic [7:0] rx_buf_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_cnt_q;
  logic [3:0] tx_div_q;
  logic tx_samp;
  logic tx_adv;
  logic ti_set;
  logic sclk_q;
  logic rx_samp;
  logic rxd_s;
  logic rxd_prev_q;
  logic [3:0] rx_div_q;
  logic [3:0] rx_idx_q;
  logic [1:0] vote_q;
  logic [7:0] rx_shift_q;
  logic ninth_q;
  logic ri_set;
  logic rb8_load;
  logic rb8_val;
  logic bit_ok;
  logic mode0;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFS_SERIAL_CONTROL) || (a == `OFS_SERIAL_BUFFER) ||
             (a == `OFS_TIMER_CONTROL) || (a == `OFS_COUNT_LOW) ||
             (a == `OFS_COUNT_HIGH) || (a == `OFS_RELOAD_LOW) ||
             (a == `OFS_RELOAD_HIGH) || (a == `OFS_RATE_CONTROL);
  endfunction : mapped

  function automatic logic is_wr(input logic en, input logic [7:0] a, input logic [7:0] o);
    is_wr = en && (a == o);
  endfunction : is_wr

  // Pin synchronisers: rxd, trigger, count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
    end else begin
      meta_q <= {count_pin, ext_trigger_pin, rxd_in};
      sync_q <= meta_q;
    end
  end
  assign rxd_s = sync_q[0];

  // Machine cycle and fixed-rate prescalers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_cnt_q <= 4'h0;
      m2_cnt_q <= 2'h0;
    end else begin
      mc_cnt_q <= (mc_cnt_q == `MC_LAST) ? 4'h0 : mc_cnt_q + 4'h1;
      m2_cnt_q <= m2_cnt_q + 2'h1;
    end
  end
  assign mc_tick = (mc_cnt_q == `MC_LAST);
  assign mc_mid = (mc_cnt_q == `MC_MID);
  assign m2_tick = rate_double_q ? m2_cnt_q[0] : (m2_cnt_q == 2'h3);
  assign mode0 = (serial_control_q.mode == serial_port_pkg::MODE_SHIFT);

  // APB: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign wr_en = psel & penable & pwrite & mapped(paddr);
  assign wdata = pwdata[7:0];
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        `OFS_SERIAL_CONTROL: prdata_q <= {24'h00_0000, serial_control_q};
        `OFS_SERIAL_BUFFER: prdata_q <= {24'h00_0000, rx_buf_q};
        `OFS_TIMER_CONTROL: prdata_q <= {24'h00_0000, tcon_q};
        `OFS_COUNT_LOW: prdata_q <= {24'h00_0000, count[7:0]};
        `OFS_COUNT_HIGH: prdata_q <= {24'h00_0000, count[15:8]};
        `OFS_RELOAD_LOW: prdata_q <= {24'h00_0000, reload[7:0]};
        `OFS_RELOAD_HIGH: prdata_q <= {24'h00_0000, reload[15:8]};
        `OFS_RATE_CONTROL: prdata_q <= {31'h0000_0000, rate_double_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign twr.wr_count_low = is_wr(wr_en, paddr, `OFS_COUNT_LOW);
  assign twr.wr_count_high = is_wr(wr_en, paddr, `OFS_COUNT_HIGH);
  assign twr.wr_reload_low = is_wr(wr_en, paddr, `OFS_RELOAD_LOW);
  assign twr.wr_reload_high = is_wr(wr_en, paddr, `OFS_RELOAD_HIGH);
  assign twr.data = wdata;

  reload_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .mc_tick(mc_tick),
    .trig_level(sync_q[1]),
    .pin_level(sync_q[2]),
    .ctrl(tcon_q),
    .twr(twr),
    .count_q(count),
    .reload_q(reload),
    .overflow(t2_ovf),
    .tf_set(tf_set),
    .exf_set(exf_set)
  );

  // Timer control; hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcon_q <= `RST_TIMER_CONTROL;
    end else begin
      if (is_wr(wr_en, paddr, `OFS_TIMER_CONTROL)) tcon_q <= wdata;
      if (tf_set) tcon_q.timer_overflow_flag <= 1'b1;
      if (exf_set) tcon_q.ext_event_flag <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_double_q <= 1'(`RST_RATE_CONTROL);
    end else if (is_wr(wr_en, paddr, `OFS_RATE_CONTROL)) begin
      rate_double_q <= wdata[`RATE_DOUBLE_BIT];
    end
  end

  assign timer_irq = tcon_q.timer_overflow_flag | tcon_q.ext_event_flag;
  assign serial_irq = serial_control_q.tx_done_flag | serial_control_q.rx_done_flag;

  // Serial control; software owns enable, hardware sets flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_q <= `RST_SERIAL_CONTROL;
    end else begin
      if (is_wr(wr_en, paddr, `OFS_SERIAL_CONTROL)) serial_control_q <= wdata;
      if (rb8_load) serial_control_q.rx_ninth_bit <= rb8_val;
      if (ti_set) serial_control_q.tx_done_flag <= 1'b1;
      if (ri_set) serial_control_q.rx_done_flag <= 1'b1;
    end
  end

  assign tx_samp = (serial_control_q.mode == serial_port_pkg::MODE_9BIT_FIXED) ? m2_tick :
                   (tcon_q.tx_clock_select ? t2_ovf : t1_overflow);
  assign rx_samp = (serial_control_q.mode == serial_port_pkg::MODE_9BIT_FIXED) ? m2_tick :
                   (tcon_q.rx_clock_select ? t2_ovf : t1_overflow);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_div_q <= 4'h0;
    end else if (tx_samp) begin
      tx_div_q <= tx_div_q + 4'h1;
    end
  end
  // shift mode at machine cycle rate
  assign tx_adv = mode0 ? mc_tick : (tx_samp && tx_div_q == `SAMPLE_LAST);
  assign ti_set = (tx_state_q == serial_port_pkg::LINK_BUSY) && tx_adv && (tx_cnt_q == 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= serial_port_pkg::LINK_IDLE;
      tx_shift_q <= 11'h7ff;
      tx_cnt_q <= 4'h0;
    end else if (is_wr(wr_en, paddr, `OFS_SERIAL_BUFFER)) begin
      tx_state_q <= serial_port_pkg::LINK_BUSY;
      if (mode0) begin
        tx_shift_q <= {3'h7, wdata};
        tx_cnt_q <= 4'h8;
      end else begin
        tx_shift_q <= {1'b1, serial_control_q.mode[1] ? serial_control_q.tx_ninth_bit : 1'b1, wdata, 1'b0};
        tx_cnt_q <= serial_control_q.mode[1] ? 4'hb : 4'ha;
      end
    end else if (tx_state_q == serial_port_pkg::LINK_BUSY && tx_adv) begin
      tx_shift_q <= {1'b1, tx_shift_q[10:1]};
      tx_cnt_q <= tx_cnt_q - 4'h1;
      if (tx_cnt_q == 4'h1) tx_state_q <= serial_port_pkg::LINK_IDLE;
    end
  end

  // Shift clock for mode zero, low in the first half of each cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b1;
    end else if (mc_tick && mode0 && (tx_state_q == serial_port_pkg::LINK_BUSY ||
                                      rx_state_q == serial_port_pkg::LINK_BUSY)) begin
      sclk_q <= 1'b0;
    end else if (mc_mid) begin
      sclk_q <= 1'b1;
    end
  end

  assign txd = mode0 ? sclk_q : tx_shift_q[0];
  assign rxd_out = tx_shift_q[0];
  assign rxd_oe = mode0 && (tx_state_q == serial_port_pkg::LINK_BUSY);

  // Receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_prev_q <= 1'b1;
    end else if (rx_samp) begin
      rxd_prev_q <= rxd_s;
    end
  end

  assign bit_ok = (vote_q[0] & vote_q[1]) | (vote_q[0] & rxd_s) | (vote_q[1] & rxd_s);

  always_comb begin
    ri_set = 1'b0;
    rb8_load = 1'b0;
    rb8_val = 1'b0;
    if (rx_state_q == serial_port_pkg::LINK_BUSY) begin
      if (mode0) begin
        // after eighth bit in shift mode
        ri_set = mc_mid && (rx_idx_q == 4'h7);
      end else if (rx_samp && rx_div_q == `SAMPLE_VOTE2) begin
        if (!serial_control_q.mode[1] && rx_idx_q == 4'h9) begin
          ri_set = ~serial_control_q.multiproc_enable | bit_ok;
          rb8_load = ri_set;
          rb8_val = bit_ok;
        end else if (serial_control_q.mode[1] && rx_idx_q == 4'ha) begin
          ri_set = ~serial_control_q.multiproc_enable | ninth_q;
          rb8_load = ri_set;
          rb8_val = ninth_q;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_q <= 8'h00;
    end else if (ri_set) begin
      rx_buf_q <= mode0 ? {rxd_s, rx_shift_q[7:1]} : rx_shift_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= serial_port_pkg::LINK_IDLE;
      rx_div_q <= 4'h0;
      rx_idx_q <= 4'h0;
      vote_q <= 2'h3;
      rx_shift_q <= 8'h00;
      ninth_q <= 1'b0;
    end else if (rx_state_q == serial_port_pkg::LINK_IDLE) begin
      rx_div_q <= 4'h0;
      rx_idx_q <= 4'h0;
      if (serial_control_q.rx_enable && mode0 && !serial_control_q.rx_done_flag && mc_tick) begin
        rx_state_q <= serial_port_pkg::LINK_BUSY;
      end else if (serial_control_q.rx_enable && !mode0 && rx_samp && rxd_prev_q && !rxd_s) begin
        rx_state_q <= serial_port_pkg::LINK_BUSY;
      end
    end else if (mode0) begin
      if (mc_mid) begin
        rx_shift_q <= {rxd_s, rx_shift_q[7:1]};
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h7) rx_state_q <= serial_port_pkg::LINK_IDLE;
      end
    end else if (rx_samp) begin
      rx_div_q <= rx_div_q + 4'h1;
      if (rx_div_q == `SAMPLE_VOTE0 || rx_div_q == `SAMPLE_VOTE1) begin
        vote_q <= {vote_q[0], rxd_s};
      end
      if (rx_div_q == `SAMPLE_VOTE2) begin
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0 && bit_ok) begin
          rx_state_q <= serial_port_pkg::LINK_IDLE;
        end else if (rx_idx_q >= 4'h1 && rx_idx_q <= 4'h8) begin
          rx_shift_q <= {bit_ok, rx_shift_q[7:1]};
        end else if (rx_idx_q == 4'h9) begin
          ninth_q <= bit_ok;
          if (!serial_control_q.mode[1]) rx_state_q <= serial_port_pkg::LINK_IDLE;
        end else if (rx_idx_q == 4'ha) begin
          rx_state_q <= serial_port_pkg::LINK_IDLE;
        end
      end
    end
  end

endmodule : serial_port_with_reload_timer

// [testbench/serial_peer_model.sv]
`timescale 1ns/100ps
module serial_peer #(parameter int BIT = 64) (
  // Clock
  input wire logic pclk,
  // Line
  input wire logic txd,
  output logic rxd
);
  logic [8:0] got_q;
  int n_got = 0;

  // Line idles high between frames
  initial rxd = 1'b1;

  task automatic send(input logic [8:0] d);
    for (int i = -1; i < 10; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i > 8) ? 1'b1 : d[i];
      repeat (BIT) @(posedge pclk);
    end
  endtask : send

  // LSB first capture
  // Resyncs on end of start bit, so bit 0 must be high
  always begin
    @(negedge txd);
    @(posedge txd);
    repeat (BIT / 2) @(posedge pclk);
    for (int k = 0; k < 9; k++) begin
      got_q[k] = txd;
      repeat (BIT) @(posedge pclk);
    end
    n_got++;
  end
endmodule : serial_peer

// [testbench/serial_port_with_reload_timer_asserts.sv]
`timescale 1ns/100ps
module serial_port_with_reload_timer_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins
  input wire logic txd,
  input wire logic ext_trigger_pin,
  input wire logic timer_irq,
  input wire logic serial_irq
);
  logic wr98;
  logic wr9c;
  logic wrc8;
  logic [1:0] mode_q;
  logic rx_en_q;
  logic sel_q;
  logic trig_q;
  assign wr98 = psel && penable && pwrite && pready && paddr == 8'h98;
  assign wr9c = psel && penable && pwrite && pready && paddr == 8'h9c;
  assign wrc8 = psel && penable && pwrite && pready && paddr == 8'hc8;

  // Software copies of mode and timer controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
      rx_en_q <= 1'b0;
      sel_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      if (wr98) begin
        mode_q <= pwdata[7:6];
        rx_en_q <= pwdata[4];
      end
      if (wrc8) begin
        sel_q <= |pwdata[5:4];
        trig_q <= pwdata[3];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rd_setup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("access without ready");
  AST_TX_START: assert property (wr9c && mode_q == 2'h2 |-> ##[1:80] !txd)
    else $error("no start bit after buffer write");
  AST_MODE: assert property (rd_setup(8'h98) |=> prdata[7:6] == mode_q)
    else $error("mode bits changed");
  AST_RX_EN: assert property (rd_setup(8'h98) |=> prdata[4] == rx_en_q)
    else $error("receive enable changed by hardware");
  AST_TIMER_IRQ: assert property (rd_setup(8'hc8) |=> (|prdata[7:6]) == $past(timer_irq))
    else $error("timer irq not flag or");
  AST_SERIAL_IRQ: assert property (rd_setup(8'h98) |=> (|prdata[1:0]) == $past(serial_irq))
    else $error("serial irq not flag or");
  AST_TF_BAUD: assert property (sel_q && !trig_q && !timer_irq && !wrc8 |=> !timer_irq)
    else $error("overflow flag in baud mode");
  AST_EXT_EVENT: assert property (trig_q && $fell(ext_trigger_pin) |-> ##[1:40] (timer_irq || ext_trigger_pin))
    else $error("trigger fall not flagged");
  AST_TXD_IDLE: assert property ($rose(presetn) |-> txd)
    else $error("txd not idle high");
endmodule : serial_port_with_reload_timer_asserts

bind serial_port_with_reload_timer serial_port_with_reload_timer_asserts u_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .txd, .ext_trigger_pin, .timer_irq, .serial_irq
);

// [testbench/serial_port_with_reload_timer_tb.sv]
`timescale 1ns/100ps
module serial_port_with_reload_timer_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ext_trigger_pin = 1'b1;
  logic count_pin = 1'b1;
  logic [1:0] t1_div = 2'h0;
  logic t1_ovf;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, txd, rxd_out, rxd_oe, peer_rxd, timer_irq, serial_irq;
  logic rxd_line;
  int fails = 0;
  int num_checks = 0;

  always #25 pclk = ~pclk;
  // First timer stand-in: one pulse every 4 clocks, bit of 64 clocks
  always @(posedge pclk) t1_div <= t1_div + 2'h1;
  assign t1_ovf = (t1_div == 2'h3);
  // Shared data pin: mode 0 transmit overrides the peer
  assign rxd_line = rxd_oe ? rxd_out : peer_rxd;

  serial_port_with_reload_timer u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .txd, .rxd_in(rxd_line), .rxd_out, .rxd_oe, .ext_trigger_pin,
    .count_pin, .t1_overflow(t1_ovf), .timer_irq, .serial_irq
  );

  serial_peer #(.BIT(64)) peer (.pclk, .txd, .rxd(peer_rxd));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rdc

  task automatic t_regs;
    rdc(8'h98, 32'h0);
    rdc(8'hc8, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk({31'h0, rerr}, 32'h1);
  endtask : t_regs

  task automatic t_tx;
    int n;
    wr(8'h98, 32'h88);
    wr(8'h9c, 32'ha5);
    for (n = 0; n < 2000 && serial_irq !== 1'b1; n++) @(posedge pclk);
    chk({23'h0, peer.got_q}, 32'h1a5);
    rdc(8'h98, 32'h8a);
    wr(8'h98, 32'h80);
    chk({31'h0, serial_irq}, 32'h0);
  endtask : t_tx

  task automatic t_rx;
    wr(8'h98, 32'h90);
    peer.send(9'h13c);
    peer.send(9'h155);
    rdc(8'h98, 32'h95);
    rdc(8'h9c, 32'h55);
    wr(8'h98, 32'hb0);
    peer.send(9'h0aa);
    rdc(8'h98, 32'hb0);
    peer.send(9'h1aa);
    rdc(8'h98, 32'hb5);
    rdc(8'h9c, 32'haa);
    wr(8'h98, 32'h80);
    peer.send(9'h177);
    rdc(8'h98, 32'h80);
  endtask : t_rx

  task automatic t_timer;
    int n;
    wr(8'hd4, 32'hf0);
    wr(8'hd8, 32'hff);
    wr(8'hcc, 32'hf0);
    wr(8'hd0, 32'hff);
    wr(8'hc8, 32'h04);
    for (n = 0; n < 400 && timer_irq !== 1'b1; n++) @(posedge pclk);
    rdc(8'hc8, 32'h84);
    rdc(8'hd0, 32'hff);
    wr(8'hd0, 32'h12);
    wr(8'hc8, 32'h0d);
    ext_trigger_pin <= 1'b0;
    for (n = 0; n < 100 && timer_irq !== 1'b1; n++) @(posedge pclk);
    rdc(8'hc8, 32'h4d);
    rdc(8'hd8, 32'h12);
    ext_trigger_pin <= 1'b1;
    wr(8'hd8, 32'hff);
    wr(8'hd4, 32'hf0);
    wr(8'hcc, 32'hf0);
    wr(8'hd0, 32'hff);
    wr(8'hc8, 32'h24);
    repeat (400) @(posedge pclk);
    rdc(8'hc8, 32'h24);
  endtask : t_timer

  task automatic t_mode1;
    wr(8'h98, 32'h50);
    wr(8'h9c, 32'h33);
    peer.send(9'h1c3);
    repeat (64) @(posedge pclk);
    chk({23'h0, peer.got_q}, 32'h133);
    rdc(8'h98, 32'h57);
    rdc(8'h9c, 32'hc3);
  endtask : t_mode1

  task automatic conclude;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_tx();
    t_rx();
    t_mode1();
    t_timer();
    conclude();
  end

  // Tests need under 10000 cycles; allow four times that
  initial begin
    #2000000;
    fails++;
    conclude();
  end
endmodule : serial_port_with_reload_timer_tb
